// file: design/hb_driver.sv
// Purpose: Driver end: serial register bank, PWM and bridge control.
// Assumes: Link pins and supply/mode levels arrive unsynchronised.
// Notes:   Frame is write bit, 7-bit address, 8-bit data, MSB first.
// What this block does
// - Power-on reset clears data, outputs off.
// - Mode pin high gives normal, configurable mode.
// - Mode pin low, or floating, selects sleep.
// - Sleep turns outputs off, resets registers.
// - Low logic supply: serial port ignores frames.
// - Supply undervoltage clears logic, outputs off.
// - After any reset the event flag reads 0.
// - Mode-pin reset not reported: flag reads 0 back in normal.
// - Each bridge: continuous or PWM drive.
// - Host enables one high side, another low.
// - Every bridge output can run PWM.
// - Three channels, each with 8-bit duty.
// - Rate codes 01/10/11 give 80/100/200 Hz.
// - Rate and duty change without glitches.
// - Active or passive free-wheel, passive default.
// - Active free-wheel only above twice dead time.
// - PWM low side, opposite high side free-wheels.
// - Host sets up PWM from tri-stated bridge.
// - Rate code 00 stops the channel off.
// - Stopped channel, active free-wheel: side opposite the enabled one on.
`default_nettype none
module hb_driver
   import hb_pwm_pkg::*;
#(
   parameter int P80  = PERIOD80_CYC,
   parameter int P100 = PERIOD100_CYC,
   parameter int P200 = PERIOD200_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic       vddOk,
   hb_link_if.device       link,
   output logic [7:0]      hsOn,
   output logic [7:0]      lsOn,
   output logic            normalMode
);
   typedef struct packed {
      logic [4:0]            s1;
      logic [4:0]            s2;
      logic [4:0]            s3;
      logic [4:0]            filt;
      logic [4:0]            bitCnt;
      logic [15:0]           shIn;
      logic [7:0]            outSh;
      logic                  sdo;
      logic                  oe;
      logic                  flag;
      logic [15:0]           act;
      logic [15:0]           chanSel;
      logic [5:0]            rate;
      logic [7:0]            fw;
      logic [2:0][7:0]       duty;
      logic [7:0]            hsOut;
      logic [7:0]            lsOut;
      logic [7:0][5:0]       dead;
      logic                  normal;
   } dev_t;

   dev_t       r_reg;
   dev_t       r_next;
   logic [2:0] chPwm;
   logic [2:0] chRun;
   logic [2:0] chFwOk;
   logic       active;

   // =========================================================
   // Register read decode
   function automatic logic [7:0] regRead(input dev_t s,
                                          input logic [6:0] a);
      case (a)
         REG_STATUS: regRead = {7'h00, s.flag};
         REG_ACT1:   regRead = s.act[7:0];
         REG_ACT2:   regRead = s.act[15:8];
         REG_SEL1:   regRead = s.chanSel[7:0];
         REG_SEL2:   regRead = s.chanSel[15:8];
         REG_RATE:   regRead = {2'h0, s.rate};
         REG_FW:     regRead = s.fw;
         REG_DUTY1:  regRead = s.duty[0];
         REG_DUTY2:  regRead = s.duty[1];
         REG_DUTY3:  regRead = s.duty[2];
         default:    regRead = 8'h00;
      endcase
   endfunction : regRead

   // =========================================================
   // PWM channels
   assign active = r_reg.filt[IN_MODE] & r_reg.filt[IN_VDD];

   for (genvar c = 0; c < 3; c++) begin : g_chan
      pwm_channel #(
         .P80  (P80),
         .P100 (P100),
         .P200 (P200)
      ) u_chan (
         .clk   (clk),
         .rst_b (rst_b),
         .ce    (ce),
         .clear (!active),
         .rate  (r_reg.rate[2*c+:2]),
         .duty  (r_reg.duty[c]),
         .pwm   (chPwm[c]),
         .run   (chRun[c]),
         .fwOk  (chFwOk[c])
      );
   end

   // =========================================================
   // Next state
   always_comb begin
      logic       sRise;
      logic       sFall;
      logic       csFall;
      logic       csRise;
      logic [7:0] rd;
      logic [1:0] sel;
      logic       hsE;
      logic       lsE;
      logic       p;
      logic       fwA;
      logic       dh;
      logic       dl;
      sRise  = 1'b0;
      sFall  = 1'b0;
      csFall = 1'b0;
      csRise = 1'b0;
      rd     = 8'h00;
      sel    = 2'h0;
      hsE    = 1'b0;
      lsE    = 1'b0;
      p      = 1'b0;
      fwA    = 1'b0;
      dh     = 1'b0;
      dl     = 1'b0;
      r_next = r_reg;
      r_next.s1 = {vddOk, link.modePin, link.sdi, link.csN, link.sclk};
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      for (int i = 0; i < 5; i++) begin
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.filt[i] = r_reg.s3[i];
         end
      end
      r_next.normal = active;
      if (!active) begin
         r_next.flag    = FLAG_RESET;
         r_next.act     = '0;
         r_next.chanSel = '0;
         r_next.rate    = '0;
         r_next.fw      = '0;
         r_next.duty    = '0;
         r_next.hsOut   = '0;
         r_next.lsOut   = '0;
         r_next.dead    = '0;
         r_next.bitCnt  = '0;
         r_next.sdo     = 1'b0;
         r_next.oe      = 1'b0;
      end else begin
         sRise  = r_reg.filt[IN_SCLK] & ~r_next.filt[IN_SCLK] ? 1'b0 :
                  ~r_reg.filt[IN_SCLK] & r_next.filt[IN_SCLK];
         sFall  = r_reg.filt[IN_SCLK] & ~r_next.filt[IN_SCLK];
         csFall = r_reg.filt[IN_CSN] & ~r_next.filt[IN_CSN];
         csRise = ~r_reg.filt[IN_CSN] & r_next.filt[IN_CSN];
         r_next.oe = ~r_next.filt[IN_CSN];
         if (csFall) begin
            r_next.bitCnt = '0;
            r_next.sdo    = r_reg.flag;
            r_next.outSh  = {7'h00, r_reg.flag} << 1;
            r_next.sdo    = 1'b0;
         end else if (csRise) begin
            if (r_reg.bitCnt == 5'(FRAME_BITS) && r_reg.shIn[WR_BIT]) begin
               case (r_reg.shIn[14:8])
                  REG_STATUS: r_next.flag = r_reg.flag | r_reg.shIn[FLAG_BIT];
                  REG_ACT1:   r_next.act[7:0] = r_reg.shIn[7:0];
                  REG_ACT2:   r_next.act[15:8] = r_reg.shIn[7:0];
                  REG_SEL1:   r_next.chanSel[7:0] = r_reg.shIn[7:0];
                  REG_SEL2:   r_next.chanSel[15:8] = r_reg.shIn[7:0];
                  REG_RATE:   r_next.rate = r_reg.shIn[5:0];
                  REG_FW:     r_next.fw = r_reg.shIn[7:0];
                  REG_DUTY1:  r_next.duty[0] = r_reg.shIn[7:0];
                  REG_DUTY2:  r_next.duty[1] = r_reg.shIn[7:0];
                  REG_DUTY3:  r_next.duty[2] = r_reg.shIn[7:0];
                  default:    r_next.flag = r_reg.flag;
               endcase
            end
         end else if (!r_reg.filt[IN_CSN]) begin
            if (sRise) begin
               r_next.shIn   = {r_reg.shIn[14:0], r_next.filt[IN_SDI]};
               r_next.bitCnt = r_reg.bitCnt + 1'b1;
            end else if (sFall) begin
               if (r_reg.bitCnt == 5'(HALF_BITS)) begin
                  rd           = regRead(r_reg, r_reg.shIn[6:0]);
                  r_next.sdo   = rd[7];
                  r_next.outSh = {rd[6:0], 1'b0};
               end else begin
                  r_next.sdo   = r_reg.outSh[7];
                  r_next.outSh = {r_reg.outSh[6:0], 1'b0};
               end
            end
         end
         for (int b = 0; b < 8; b++) begin
            sel = r_reg.chanSel[2*b+:2];
            hsE = r_reg.act[2*b];
            lsE = r_reg.act[2*b+1];
            if (hsE & lsE) begin
               dh = 1'b0;
               dl = 1'b0;
            end else if (sel == 2'h0) begin
               dh = hsE;
               dl = lsE;
            end else begin
               p   = chPwm[sel-1'b1];
               fwA = r_reg.fw[b] &
                     (chRun[sel-1'b1] ? (~p & chFwOk[sel-1'b1]) : 1'b1);
               if (hsE) begin
                  dh = p;
                  dl = fwA;
               end else if (lsE) begin
                  dl = p;
                  dh = fwA;
               end else begin
                  dh = 1'b0;
                  dl = 1'b0;
               end
            end
            if ((r_reg.hsOut[b] & ~dh) | (r_reg.lsOut[b] & ~dl)) begin
               r_next.hsOut[b] = 1'b0;
               r_next.lsOut[b] = 1'b0;
               r_next.dead[b]  = 6'(DEAD_CYC);
            end else if (r_reg.dead[b] != 6'h00) begin
               r_next.dead[b] = r_reg.dead[b] - 1'b1;
            end else begin
               r_next.hsOut[b] = dh;
               r_next.lsOut[b] = dl;
            end
         end
      end
   end

   // =========================================================
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= '0;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign hsOn       = r_reg.hsOut;
   assign lsOn       = r_reg.lsOut;
   assign normalMode = r_reg.normal;
   assign link.sdo   = r_reg.sdo;
   assign link.sdoOe = r_reg.oe;
endmodule : hb_driver
`default_nettype wire

// file: design/hb_pwm_pkg.sv
// Purpose: Shared constants and types for the half-bridge PWM link.
// Assumes: Core clock of 200 MHz on both ends.
// Notes:   Register offsets are 7-bit frame addresses.
`default_nettype none
package hb_pwm_pkg;
   // =========================================================
   // Clock and timing
   localparam int CLK_HZ         = 200_000_000;
   localparam int CLK_NS         = 5;
   localparam int RATE80_HZ      = 80;
   localparam int RATE100_HZ     = 100;
   localparam int RATE200_HZ     = 200;
   localparam int PERIOD80_CYC   = CLK_HZ / RATE80_HZ;
   localparam int PERIOD100_CYC  = CLK_HZ / RATE100_HZ;
   localparam int PERIOD200_CYC  = CLK_HZ / RATE200_HZ;
   localparam int CNT_W          = 22;
   localparam int DEAD_NS        = 250;
   localparam int DEAD_CYC       = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEAD_SUM_CYC   = 2 * DEAD_CYC;
   localparam int SCLK_NS        = 200;
   localparam int SCLK_HALF_CYC  = (SCLK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
   localparam int LEAD_NS        = 250;
   localparam int LEAD_CYC       = (LEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int LAG_NS         = 250;
   localparam int LAG_CYC        = (LAG_NS + CLK_NS - 1) / CLK_NS;
   localparam int CSN_HIGH_NS    = 5000;
   localparam int CSN_HIGH_CYC   = (CSN_HIGH_NS + CLK_NS - 1) / CLK_NS;
   // =========================================================
   // Frame layout
   localparam int FRAME_BITS     = 16;
   localparam int WR_BIT         = 15;
   localparam int HALF_BITS      = 8;
   // =========================================================
   // Device register map and fields
   localparam logic [6:0] REG_STATUS = 7'h00;
   localparam logic [6:0] REG_ACT1   = 7'h01;
   localparam logic [6:0] REG_ACT2   = 7'h02;
   localparam logic [6:0] REG_SEL1   = 7'h03;
   localparam logic [6:0] REG_SEL2   = 7'h04;
   localparam logic [6:0] REG_RATE   = 7'h05;
   localparam logic [6:0] REG_FW     = 7'h06;
   localparam logic [6:0] REG_DUTY1  = 7'h07;
   localparam logic [6:0] REG_DUTY2  = 7'h08;
   localparam logic [6:0] REG_DUTY3  = 7'h09;
   localparam int         FLAG_BIT   = 0;
   localparam logic       FLAG_RESET = 1'h0;
   localparam logic [1:0] RATE_OFF   = 2'h0;
   localparam logic [1:0] RATE_80    = 2'h1;
   localparam logic [1:0] RATE_100   = 2'h2;
   localparam logic [1:0] RATE_200   = 2'h3;
   // =========================================================
   // Synchroniser input positions on the device
   localparam int IN_SCLK = 0;
   localparam int IN_CSN  = 1;
   localparam int IN_SDI  = 2;
   localparam int IN_MODE = 3;
   localparam int IN_VDD  = 4;
   // =========================================================
   // Host register map
   localparam logic [1:0] HREG_TX    = 2'h0;
   localparam logic [1:0] HREG_RX    = 2'h1;
   localparam logic [1:0] HREG_STAT  = 2'h2;
   localparam logic [1:0] HREG_MODE  = 2'h3;
   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_LEAD  = 3'h1,
      H_SHIFT = 3'h2,
      H_LAG   = 3'h3,
      H_GAP   = 3'h4
   } host_state_t;
endpackage : hb_pwm_pkg
`default_nettype wire

// file: design/hb_link_if.sv
// Purpose: Serial link and mode pin between controller and driver.
// Assumes: The data-out line is pulled low while released.
// Notes:   An undriven mode pin reads low.
`default_nettype none
interface hb_link_if;
   logic sclk;
   logic csN;
   logic sdi;
   logic sdo;
   logic sdoOe;
   logic sdoLine;
   logic modePin;
   // =========================================================
   // Line resolution
   assign sdoLine = sdoOe & sdo;
   modport device (input sclk, input csN, input sdi, input modePin,
                   output sdo, output sdoOe);
   modport host (output sclk, output csN, output sdi, output modePin,
                 input sdoLine);
endinterface : hb_link_if
`default_nettype wire

// file: design/pwm_channel.sv
// Purpose: One PWM channel with rate and duty taken at period end.
// Assumes: Rate codes from the package.
// Notes:   A stopped channel takes new settings at once.
`default_nettype none
module pwm_channel
   import hb_pwm_pkg::*;
#(
   parameter int P80  = PERIOD80_CYC,
   parameter int P100 = PERIOD100_CYC,
   parameter int P200 = PERIOD200_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic       clear,
   input  wire logic [1:0] rate,
   input  wire logic [7:0] duty,
   output logic            pwm,
   output logic            run,
   output logic            fwOk
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] onCnt;
      logic [1:0]       rate;
      logic             pwm;
      logic             fwOk;
   } chan_t;

   chan_t r_reg;
   chan_t r_next;

   // =========================================================
   // Helpers
   function automatic logic [CNT_W-1:0] periodOf(input logic [1:0] code);
      case (code)
         RATE_80:  periodOf = CNT_W'(P80);
         RATE_100: periodOf = CNT_W'(P100);
         RATE_200: periodOf = CNT_W'(P200);
         default:  periodOf = '0;
      endcase
   endfunction : periodOf

   function automatic logic [CNT_W-1:0] onTime(input logic [7:0] d,
                                               input logic [1:0] code);
      logic [31:0] p;
      p = 32'(d) * 32'(periodOf(code));
      onTime = p[CNT_W+7:8];
   endfunction : onTime

   // =========================================================
   // Next state
   always_comb begin
      r_next = r_reg;
      if (clear) begin
         r_next = '0;
      end else begin
         if (r_reg.rate == RATE_OFF ||
             r_reg.cnt == periodOf(r_reg.rate) - 1'b1) begin
            r_next.rate  = rate;
            r_next.cnt   = '0;
            r_next.onCnt = onTime(duty, rate);
            r_next.fwOk  = (r_next.onCnt > CNT_W'(DEAD_SUM_CYC)) &&
                           (periodOf(rate) - r_next.onCnt >
                            CNT_W'(DEAD_SUM_CYC));
         end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
         end
         r_next.pwm = (r_next.rate != RATE_OFF) &&
                      (r_next.cnt < r_next.onCnt);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= '0;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign pwm  = r_reg.pwm;
   assign run  = r_reg.rate != RATE_OFF;
   assign fwOk = r_reg.fwOk;
endmodule : pwm_channel
`default_nettype wire

// file: design/hb_controller.sv
// Purpose: Controller end: frames host register writes onto the link.
// Assumes: Software waits for the controller to return to idle before the next frame.
// Notes:   Clock idles low, data sampled on the rising edge.
`default_nettype none
module hb_controller
   import hb_pwm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic [1:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   hb_link_if.host          link
);
   typedef struct packed {
      host_state_t st;
      logic [9:0]  cnt;
      logic [4:0]  bitCnt;
      logic        sclk;
      logic        csN;
      logic        sdi;
      logic [15:0] txSh;
      logic [15:0] rxSh;
      logic [15:0] rx;
      logic        done;
      logic        mode;
      logic [15:0] rdata;
      logic [2:0]  sy;
      logic        filt;
   } host_t;

   host_t r_reg;
   host_t r_next;

   // =========================================================
   // Next state
   always_comb begin
      logic doneSet;
      doneSet = 1'b0;
      r_next = r_reg;
      r_next.sy = {r_reg.sy[1:0], link.sdoLine};
      if (r_reg.sy[1] == r_reg.sy[2]) begin
         r_next.filt = r_reg.sy[2];
      end
      r_next.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            HREG_RX:   r_next.rdata = r_reg.rx;
            HREG_STAT: r_next.rdata = {14'h0000, r_reg.done,
                                       r_reg.st != H_IDLE};
            HREG_MODE: r_next.rdata = {15'h0000, r_reg.mode};
            default:   r_next.rdata = 16'h0000;
         endcase
      end
      case (r_reg.st)
         H_IDLE: begin
            r_next.csN = 1'b1;
            if (wr && addr == HREG_TX) begin
               r_next.txSh   = wdata;
               r_next.sdi    = wdata[15];
               r_next.csN    = 1'b0;
               r_next.bitCnt = '0;
               r_next.cnt    = 10'(LEAD_CYC - 1);
               r_next.st     = H_LEAD;
            end
         end
         H_LEAD: begin
            if (r_reg.cnt != 10'h000) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               r_next.sclk = 1'b1;
               r_next.rxSh = {r_reg.rxSh[14:0], r_reg.filt};
               r_next.cnt  = 10'(SCLK_HALF_CYC - 1);
               r_next.st   = H_SHIFT;
            end
         end
         H_SHIFT: begin
            if (r_reg.cnt != 10'h000) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               r_next.cnt = 10'(SCLK_HALF_CYC - 1);
               if (r_reg.sclk) begin
                  r_next.sclk   = 1'b0;
                  r_next.bitCnt = r_reg.bitCnt + 1'b1;
                  r_next.txSh   = {r_reg.txSh[14:0], 1'b0};
                  r_next.sdi    = r_reg.txSh[14];
                  if (r_reg.bitCnt == 5'(FRAME_BITS - 1)) begin
                     r_next.cnt = 10'(LAG_CYC - 1);
                     r_next.st  = H_LAG;
                  end
               end else begin
                  r_next.sclk = 1'b1;
                  r_next.rxSh = {r_reg.rxSh[14:0], r_reg.filt};
               end
            end
         end
         H_LAG: begin
            if (r_reg.cnt != 10'h000) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               r_next.csN = 1'b1;
               r_next.rx  = r_reg.rxSh;
               doneSet    = 1'b1;
               r_next.cnt = 10'(CSN_HIGH_CYC - 1);
               r_next.st  = H_GAP;
            end
         end
         H_GAP: begin
            if (r_reg.cnt != 10'h000) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               r_next.st = H_IDLE;
            end
         end
         default: begin
            r_next.st = H_IDLE;
         end
      endcase
      if (wr && addr == HREG_STAT && wdata[1]) begin
         r_next.done = 1'b0;
      end
      if (wr && addr == HREG_MODE) begin
         r_next.mode = wdata[0];
      end
      if (doneSet) begin
         r_next.done = 1'b1;
      end
   end

   // =========================================================
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg     <= '0;
         r_reg.csN <= 1'b1;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign rdata        = r_reg.rdata;
   assign link.sclk    = r_reg.sclk;
   assign link.csN     = r_reg.csN;
   assign link.sdi     = r_reg.sdi;
   assign link.modePin = r_reg.mode;
endmodule : hb_controller
`default_nettype wire

// file: tb/hb_pwm_asserts.sv
// Purpose: Link and output checks for the half-bridge pair.
// Assumes: Driver inputs pass a short synchroniser and filter.
// Notes:   Bounds allow for those filter delays.
`default_nettype none
module hb_pwm_asserts (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       csN,
   input wire logic       sdoOe,
   input wire logic       sdoLine,
   input wire logic       modePin,
   input wire logic       vddOk,
   input wire logic       normalMode,
   input wire logic [7:0] hsOn,
   input wire logic [7:0] lsOn
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // =========================================================
   // Output safety
   chk_no_overlap: assert property ((hsOn & lsOn) == 8'h00)
      else $error("both switches of a bridge on");
   for (genvar b = 0; b < 8; b++) begin : g_dead
      chk_dead_hl: assert property ($fell(hsOn[b]) |-> (!lsOn[b])[*8])
         else $error("low side on inside dead time");
      chk_dead_lh: assert property ($fell(lsOn[b]) |-> (!hsOn[b])[*8])
         else $error("high side on inside dead time");
   end
   // =========================================================
   // Modes and resets
   chk_sleep_mode: assert property ((!modePin)[*8] |=> !normalMode)
      else $error("normal mode with mode pin low");
   chk_sleep_off: assert property (
      (!normalMode)[*2] |-> (hsOn | lsOn) == 8'h00)
      else $error("output on while asleep");
   chk_uv_off: assert property (
      (!vddOk)[*8] |=> !normalMode && hsOn == 8'h00)
      else $error("logic still active in undervoltage");
   chk_uv_quiet: assert property ((!vddOk)[*8] |=> !sdoOe)
      else $error("serial output driven in undervoltage");
   chk_wake_cause: assert property (
      $rose(normalMode) |-> $past(modePin, 4) && $past(vddOk, 4))
      else $error("normal mode without mode pin and supply");
   chk_sdo_start: assert property (
      $fell(csN) && normalMode |-> ##[1:8] (sdoOe && !sdoLine))
      else $error("serial output not driven low at frame start");
   cover property ($fell(csN));
   cover property ($rose(normalMode));
   cover property ($rose(lsOn[1]));
endmodule : hb_pwm_asserts
`default_nettype wire

// file: tb/tb_half_bridge_pwm_control.sv
// Purpose: Self-checking bench for controller and driver back to back.
// Assumes: Short PWM periods through the driver parameters.
// Notes:   Device registers are reached through link frames.
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   errTotal++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_half_bridge_pwm_control
   import hb_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P80S = 2560, P100S = 2048, P200S = 1024;
   logic clk, rst_b, ce, vddOk, wr, rd, normalMode, hsSeen;
   logic [1:0]  addr;
   logic [15:0] wdata, rdata;
   logic [7:0]  hsOn, lsOn;
   logic [31:0] seed;
   int          errTotal, comparisons;
   hb_link_if link();
   hb_controller hb_controller_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .link(link));
   hb_driver #(.P80(P80S), .P100(P100S), .P200(P200S)) hb_driver_inst (
      .clk(clk), .rst_b(rst_b), .ce(ce), .vddOk(vddOk), .link(link),
      .hsOn(hsOn), .lsOn(lsOn), .normalMode(normalMode));
   hb_pwm_asserts hb_pwm_asserts_inst (.clk(clk), .rst_b(rst_b),
      .csN(link.csN), .sdoOe(link.sdoOe), .sdoLine(link.sdoLine),
      .modePin(link.modePin), .vddOk(vddOk), .normalMode(normalMode),
      .hsOn(hsOn), .lsOn(lsOn));
   // =========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int per(input int c);
      return (c == 1) ? P80S : (c == 2) ? P100S : P200S;
   endfunction : per
   task automatic regWr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : regWr
   task automatic regRd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : regRd
   task automatic xfer(input logic [15:0] f, output logic [7:0] d);
      logic [15:0] s;
      regWr(HREG_TX, f);
      s = 16'h0001;
      for (int i = 0; i < 4000 && s[0] !== 1'b0; i++) regRd(HREG_STAT, s);
      `CHK("idle", 1'b0, s[0])
      regRd(HREG_RX, s);
      d = s[7:0];
   endtask : xfer
   task automatic waitLs(input logic v, output int n);
      for (n = 0; n < 6000 && lsOn[1] !== v; n++) begin
         @(posedge clk);
         if (hsOn[1] === 1'b1) hsSeen = 1'b1;
      end
      `CHK("lsEdge", v, lsOn[1])
   endtask : waitLs
   task automatic testDone;
      $display("comparisons %0d errors %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : testDone
   // =========================================================
   // Clock, watchdog and tests
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #450000;
      errTotal++;
      testDone();
   end
   initial begin
      int n, ex;
      logic [7:0] d, duty;
      {rst_b, wr, rd, hsSeen, addr, wdata} = '0;
      {ce, vddOk} = 2'b11;
      seed = 32'h8932;
      errTotal = 0;
      comparisons = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         if (k == 1) regWr(HREG_MODE, 16'h0000);
         if (k == 2) vddOk <= 1'b0;
         repeat (20) @(posedge clk);
         vddOk <= 1'b1;
         regWr(HREG_MODE, 16'h0001);
         for (n = 0; n < 100 && normalMode !== 1'b1; n++) @(posedge clk);
         `CHK("normal", 1'b1, normalMode)
         xfer({1'b0, REG_STATUS, 8'h00}, d);
         `CHK("flag", 8'h00, d)
         xfer({1'b0, REG_ACT1, 8'h00}, d);
         `CHK("act1", 8'h00, d)
         xfer({1'b1, REG_STATUS, 8'h01}, d);
         xfer({1'b1, REG_ACT1, 8'h01}, d);
         xfer({1'b0, REG_STATUS, 8'h00}, d);
         `CHK("flagSet", 8'h01, d)
      end
      xfer({1'b1, REG_ACT1, 8'h09}, d);
      repeat (100) @(posedge clk);
      `CHK("hsOn", 8'h01, hsOn)
      `CHK("lsOn", 8'h02, lsOn)
      xfer({1'b1, REG_ACT1, 8'h03}, d);
      repeat (100) @(posedge clk);
      `CHK("bridge1", 2'b00, {hsOn[0], lsOn[0]})
      xfer({1'b1, REG_SEL1, 8'h04}, d);
      xfer({1'b1, REG_ACT1, 8'h08}, d);
      repeat (P80S) @(posedge clk);
      `CHK("stopped", 1'b0, lsOn[1])
      for (int c = 1; c < 4; c++) begin
         seed = lfsr(seed);
         duty = {2'b01, seed[5:0]};
         xfer({1'b1, REG_DUTY1, duty}, d);
         xfer({1'b1, REG_RATE, 6'h00, c[1:0]}, d);
         waitLs(1'b1, n);
         waitLs(1'b0, n);
         waitLs(1'b1, n);
         waitLs(1'b0, n);
         ex = int'(duty) * per(c) / 256 - n;
         `CHK("onTime", 1'b1, ex <= 52 && ex >= -52)
      end
      `CHK("passiveFw", 1'b0, hsSeen)
      xfer({1'b1, REG_FW, 8'h02}, d);
      hsSeen = 1'b0;
      for (int i = 0; i < 2; i++) begin
         waitLs(1'b0, n);
         waitLs(1'b1, n);
      end
      `CHK("activeFw", 1'b1, hsSeen)
      xfer({1'b1, REG_ACT1, 8'h04}, d);
      xfer({1'b1, REG_RATE, 8'h00}, d);
      repeat (P200S) @(posedge clk);
      `CHK("stopFw", 2'b01, {hsOn[1], lsOn[1]})
      testDone();
   end
endmodule : tb_half_bridge_pwm_control
`default_nettype wire
